//--- pkg/fuse_prog_pkg.sv
/*
 * Constants, command codes and pin bundles for the parallel
 * lock/fuse programming port and its serial download front end.
 * Assumes a single 200 MHz clock; all pins are synchronous to it.
 */
package fuse_prog_pkg;
    localparam int CLK_PERIOD_NS = 5;
    localparam int T_WR_MIN_NS = 3_700_000;
    localparam int T_WR_MAX_NS = 5_000_000;
    localparam int T_ERASE_MIN_NS = 7_500_000;
    localparam int T_ERASE_MAX_NS = 10_000_000;
    localparam int T_BUSY_START_MAX_NS = 1_000;
    localparam int T_RELEASE_MAX_NS = 250;
    localparam int WR_MIN_CYC = (T_WR_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WR_MAX_CYC = T_WR_MAX_NS / CLK_PERIOD_NS;
    localparam int ERASE_MIN_CYC = (T_ERASE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ERASE_MAX_CYC = T_ERASE_MAX_NS / CLK_PERIOD_NS;
    localparam int BUSY_START_MAX_CYC = T_BUSY_START_MAX_NS / CLK_PERIOD_NS;
    localparam int RELEASE_MAX_CYC = T_RELEASE_MAX_NS / CLK_PERIOD_NS;
    localparam int BUSY_CNT_W = 21;

    localparam logic [7:0] CMD_NONE = 8'h00;
    localparam logic [7:0] CMD_LOCK_WR = 8'h20;
    localparam logic [7:0] CMD_FUSE_RD = 8'h04;
    localparam logic [7:0] CMD_SIG_RD = 8'h08;
    localparam logic [7:0] CMD_FUSE_WR = 8'h40;
    localparam logic [7:0] CMD_FLASH_WR = 8'h10;
    localparam logic [7:0] CMD_EEPROM_WR = 8'h11;
    localparam logic [7:0] CMD_CHIP_ERASE = 8'h80;

    localparam logic [1:0] LOAD_ADDR_LO = 2'h0;
    localparam logic [1:0] LOAD_DATA = 2'h1;
    localparam logic [1:0] LOAD_CMD = 2'h2;

    localparam logic [2:0] IDX_FUSE_LO = 3'h0;
    localparam logic [2:0] IDX_FUSE_HI = 3'h1;
    localparam logic [2:0] IDX_FUSE_EXT = 3'h2;
    localparam logic [2:0] IDX_LOCK = 3'h3;
    localparam logic [2:0] IDX_SIG0 = 3'h4;
    localparam logic [2:0] IDX_CAL = 3'h7;
    localparam logic [7:0] SIG_LAST = 8'h02;
    localparam logic [7:0] BYTE_ERASED = 8'hFF;
    localparam logic [7:0] DATA_RESET = 8'h00;
    // Arbitrary neutral contents: fuses, lock, signature (arbitrary), calibration
    localparam logic [63:0] STORE_INIT = 64'h80_5C_5B_5A_FF_F7_EF_DF;

    localparam logic [7:0] SER_EN_BYTE0 = 8'hAC;
    localparam logic [7:0] SER_EN_BYTE1 = 8'h53;
    localparam logic [4:0] SER_ECHO_BIT = 5'h0F;
    localparam logic [4:0] SER_LAST_BIT = 5'h1F;

    typedef struct packed {
        logic load_strobe;
        logic [1:0] load_sel;
        logic byte_select_hi;
        logic byte_select_lo;
        logic out_en_n;
        logic prog_strobe_n;
    } par_ctrl_t;

    typedef struct packed {
        logic reset_n;
        logic sck;
        logic prog_serial_in;
    } ser_pins_t;
endpackage

//--- verilog/nv_byte_store.sv
/*
 * Eight-byte nonvolatile store: fuses, lock, signature, calibration.
 * Read data is registered. Lock writes can only clear bits; erase
 * sets the lock byte back to all ones. Assumes one clock domain.
 */
`timescale 1ns/1ps
module nv_byte_store #(
    parameter logic [63:0] INIT = fuse_prog_pkg::STORE_INIT
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic clk_en_i,
    input wire logic [2:0] rd_idx_i,
    output logic [7:0] rd_data_o,
    input wire logic lock_wr_i,
    input wire logic [7:0] lock_data_i,
    input wire logic erase_i
);
    logic [7:0] mem_reg [8];
    logic [7:0] mem_next [8];
    logic [7:0] rd_reg, rd_next;

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            mem_next[i] = mem_reg[i];
        end
        if (erase_i) begin
            mem_next[fuse_prog_pkg::IDX_LOCK] = fuse_prog_pkg::BYTE_ERASED;
        end else if (lock_wr_i) begin
            // Only zeros take effect; a programmed bit returns only on erase
            mem_next[fuse_prog_pkg::IDX_LOCK] = mem_reg[fuse_prog_pkg::IDX_LOCK] & lock_data_i;
        end
        rd_next = mem_reg[rd_idx_i];
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < 8; i++) begin
                mem_reg[i] <= INIT[i*8 +: 8];
            end
            rd_reg <= fuse_prog_pkg::DATA_RESET;
        end else if (clk_en_i) begin
            for (int i = 0; i < 8; i++) begin
                mem_reg[i] <= mem_next[i];
            end
            rd_reg <= rd_next;
        end
    end

    assign rd_data_o = rd_reg;

    lock_monotonic_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        ((mem_reg[fuse_prog_pkg::IDX_LOCK] & ~$past(mem_reg[fuse_prog_pkg::IDX_LOCK])) != 8'h00)
        |-> $past(erase_i))
        else $error("lock bit unprogrammed without erase");
endmodule // nv_byte_store

//--- verilog/fuse_lock_prog.sv
/*
 * Parallel programming command interpreter for lock writes and
 * fuse/lock/signature/calibration readback, busy timing, and the
 * serial download enable handshake.
 * Assumes all pins already synchronous to mclk_i; the pad resolves
 * the data bus from data_oe_o.
 */
// Operation
// - Load strobe captures command byte
// - Code 20h selects lock write
// - Zero data bits program lock bits
// - Program strobe fall starts write, busy
// - Lock bits cleared only by erase
// - Code 04h selects fuse/lock readback
// - Byte selects pick fuse or lock byte
// - Programmed bits read as zero
// - Code 08h reads signature by address
// - Byte select low high reads calibration
// - Output enable high releases bus
// - Busy asserted within one microsecond
// - Writes hold busy 3.7 to 5 ms
// - Erase holds busy 7.5 to 10 ms
// - Serial mode only while reset low
// - Serial uses dedicated programming data pins
`timescale 1ns/1ps
module fuse_lock_prog #(
    parameter int WR_CYC = fuse_prog_pkg::WR_MIN_CYC,
    parameter int ERASE_CYC = fuse_prog_pkg::ERASE_MIN_CYC
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic clk_en_i,
    input wire fuse_prog_pkg::par_ctrl_t par_ctrl_i,
    input wire logic [7:0] data_i,
    output logic [7:0] data_o,
    output logic data_oe_o,
    output logic ready_busy_n_o,
    input wire fuse_prog_pkg::ser_pins_t ser_pins_i,
    output logic prog_serial_out_o,
    output logic serial_enabled_o
);
    localparam logic [fuse_prog_pkg::BUSY_CNT_W-1:0] WR_LIM = fuse_prog_pkg::BUSY_CNT_W'(WR_CYC - 1);
    localparam logic [fuse_prog_pkg::BUSY_CNT_W-1:0] ERASE_LIM = fuse_prog_pkg::BUSY_CNT_W'(ERASE_CYC - 1);
    localparam logic [fuse_prog_pkg::BUSY_CNT_W-1:0] WR_LEN = fuse_prog_pkg::BUSY_CNT_W'(WR_CYC);
    localparam logic [fuse_prog_pkg::BUSY_CNT_W-1:0] ERASE_LEN = fuse_prog_pkg::BUSY_CNT_W'(ERASE_CYC);

    // Parallel command path
    logic [7:0] cmd_reg, cmd_next;
    logic [7:0] addr_lo_reg, addr_lo_next;
    logic [7:0] wdata_reg, wdata_next;
    logic strobe_prev_reg, strobe_prev_next;
    logic wr_prev_n_reg, wr_prev_n_next;
    logic busy_reg, busy_next;
    logic [fuse_prog_pkg::BUSY_CNT_W-1:0] cnt_reg, cnt_next, lim_reg, lim_next;
    logic [7:0] dout_reg, dout_next;
    logic oe_reg, oe_next;
    logic rd_valid_reg, rd_valid_next;
    logic load_rise, wr_fall, is_write, is_read;
    logic lock_wr, erase;
    logic [2:0] rd_idx;
    logic [7:0] store_rd;

    always_comb begin
        load_rise = par_ctrl_i.load_strobe && !strobe_prev_reg;
        wr_fall = !par_ctrl_i.prog_strobe_n && wr_prev_n_reg;
        is_write = (cmd_reg == fuse_prog_pkg::CMD_LOCK_WR) || (cmd_reg == fuse_prog_pkg::CMD_FUSE_WR)
            || (cmd_reg == fuse_prog_pkg::CMD_FLASH_WR) || (cmd_reg == fuse_prog_pkg::CMD_EEPROM_WR);
        is_read = (cmd_reg == fuse_prog_pkg::CMD_FUSE_RD) || (cmd_reg == fuse_prog_pkg::CMD_SIG_RD);
        cmd_next = cmd_reg;
        addr_lo_next = addr_lo_reg;
        wdata_next = wdata_reg;
        strobe_prev_next = par_ctrl_i.load_strobe;
        wr_prev_n_next = par_ctrl_i.prog_strobe_n;
        busy_next = busy_reg;
        cnt_next = cnt_reg;
        lim_next = lim_reg;
        lock_wr = 1'b0;
        erase = 1'b0;
        // Loads and strobes during busy are dropped, not queued
        if (load_rise && !busy_reg) begin
            if (par_ctrl_i.load_sel == fuse_prog_pkg::LOAD_CMD) begin
                cmd_next = data_i;
            end else if (par_ctrl_i.load_sel == fuse_prog_pkg::LOAD_ADDR_LO) begin
                addr_lo_next = data_i;
            end else if (par_ctrl_i.load_sel == fuse_prog_pkg::LOAD_DATA) begin
                wdata_next = data_i;
            end
        end
        if (busy_reg) begin
            if (cnt_reg == lim_reg) begin
                busy_next = 1'b0;
            end else begin
                cnt_next = cnt_reg + 1'b1;
            end
        end else if (wr_fall && (is_write || cmd_reg == fuse_prog_pkg::CMD_CHIP_ERASE)) begin
            busy_next = 1'b1;
            cnt_next = '0;
            lim_next = (cmd_reg == fuse_prog_pkg::CMD_CHIP_ERASE) ? ERASE_LIM : WR_LIM;
            lock_wr = (cmd_reg == fuse_prog_pkg::CMD_LOCK_WR);
            erase = (cmd_reg == fuse_prog_pkg::CMD_CHIP_ERASE);
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cmd_reg <= fuse_prog_pkg::CMD_NONE;
            addr_lo_reg <= fuse_prog_pkg::DATA_RESET;
            wdata_reg <= fuse_prog_pkg::BYTE_ERASED;
            strobe_prev_reg <= 1'b0;
            wr_prev_n_reg <= 1'b1;
            busy_reg <= 1'b0;
            cnt_reg <= '0;
            lim_reg <= '0;
        end else if (clk_en_i) begin
            cmd_reg <= cmd_next;
            addr_lo_reg <= addr_lo_next;
            wdata_reg <= wdata_next;
            strobe_prev_reg <= strobe_prev_next;
            wr_prev_n_reg <= wr_prev_n_next;
            busy_reg <= busy_next;
            cnt_reg <= cnt_next;
            lim_reg <= lim_next;
        end
    end

    // Readback select; stored bytes keep programmed bits as zero
    always_comb begin
        rd_idx = fuse_prog_pkg::IDX_FUSE_LO;
        if (cmd_reg == fuse_prog_pkg::CMD_FUSE_RD) begin
            rd_idx = (par_ctrl_i.byte_select_hi && par_ctrl_i.byte_select_lo) ? fuse_prog_pkg::IDX_FUSE_HI
                : par_ctrl_i.byte_select_hi ? fuse_prog_pkg::IDX_FUSE_EXT
                : par_ctrl_i.byte_select_lo ? fuse_prog_pkg::IDX_LOCK
                : fuse_prog_pkg::IDX_FUSE_LO;
        end else if (par_ctrl_i.byte_select_lo) begin
            rd_idx = fuse_prog_pkg::IDX_CAL;
        end else begin
            rd_idx = fuse_prog_pkg::IDX_SIG0 + addr_lo_reg[2:0];
        end
        rd_valid_next = (cmd_reg != fuse_prog_pkg::CMD_SIG_RD) || par_ctrl_i.byte_select_lo
            || (addr_lo_reg <= fuse_prog_pkg::SIG_LAST);
        // Out-of-range signature index reads as all ones
        dout_next = rd_valid_reg ? store_rd : fuse_prog_pkg::BYTE_ERASED;
        oe_next = !par_ctrl_i.out_en_n && is_read;
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dout_reg <= fuse_prog_pkg::DATA_RESET;
            oe_reg <= 1'b0;
            rd_valid_reg <= 1'b1;
        end else if (clk_en_i) begin
            dout_reg <= dout_next;
            oe_reg <= oe_next;
            rd_valid_reg <= rd_valid_next;
        end
    end

    nv_byte_store u_store (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .clk_en_i(clk_en_i),
        .rd_idx_i(rd_idx),
        .rd_data_o(store_rd),
        .lock_wr_i(lock_wr),
        .lock_data_i(wdata_reg),
        .erase_i(erase)
    );

    // Serial download front end; sck sampled, so it must stay slow
    logic sck_prev_reg, sck_prev_next;
    logic [31:0] sin_reg, sin_next;
    logic [7:0] sout_reg, sout_next;
    logic [4:0] sbit_reg, sbit_next;
    logic sdo_reg, sdo_next;
    logic sen_reg, sen_next;

    always_comb begin
        sck_prev_next = ser_pins_i.sck;
        sin_next = sin_reg;
        sout_next = sout_reg;
        sbit_next = sbit_reg;
        sdo_next = sdo_reg;
        sen_next = sen_reg;
        if (ser_pins_i.reset_n) begin
            // Leaving reset drops the mode and any enable
            sbit_next = '0;
            sen_next = 1'b0;
            sdo_next = 1'b0;
        end else if (ser_pins_i.sck && !sck_prev_reg) begin
            sin_next = {sin_reg[30:0], ser_pins_i.prog_serial_in};
            sbit_next = sbit_reg + 1'b1;
            if (sbit_reg == fuse_prog_pkg::SER_ECHO_BIT) begin
                sout_next = {sin_reg[6:0], ser_pins_i.prog_serial_in};
            end
            if (sbit_reg == fuse_prog_pkg::SER_LAST_BIT && sin_reg[30:23] == fuse_prog_pkg::SER_EN_BYTE0
                && sin_reg[22:15] == fuse_prog_pkg::SER_EN_BYTE1) begin
                sen_next = 1'b1;
            end
        end else if (!ser_pins_i.sck && sck_prev_reg) begin
            sdo_next = sout_reg[7];
            sout_next = {sout_reg[6:0], 1'b0};
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sck_prev_reg <= 1'b0;
            sin_reg <= '0;
            sout_reg <= '0;
            sbit_reg <= '0;
            sdo_reg <= 1'b0;
            sen_reg <= 1'b0;
        end else if (clk_en_i) begin
            sck_prev_reg <= sck_prev_next;
            sin_reg <= sin_next;
            sout_reg <= sout_next;
            sbit_reg <= sbit_next;
            sdo_reg <= sdo_next;
            sen_reg <= sen_next;
        end
    end

    assign data_o = dout_reg;
    assign data_oe_o = oe_reg;
    assign ready_busy_n_o = !busy_reg;
    assign prog_serial_out_o = sdo_reg;
    assign serial_enabled_o = sen_reg;

    // Checker-only busy length, kept apart from the design's own counter
    logic [fuse_prog_pkg::BUSY_CNT_W-1:0] blen_reg, blen_next;

    always_comb begin
        blen_next = ready_busy_n_o ? '0 : blen_reg + 1'b1;
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            blen_reg <= '0;
        end else if (clk_en_i) begin
            blen_reg <= blen_next;
        end
    end

    cmd_capture_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (clk_en_i && load_rise && !busy_reg && par_ctrl_i.load_sel == fuse_prog_pkg::LOAD_CMD)
        |=> cmd_reg == $past(data_i))
        else $error("command byte not captured");
    busy_start_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (clk_en_i && wr_fall && !busy_reg && cmd_reg == fuse_prog_pkg::CMD_LOCK_WR)
        |=> !ready_busy_n_o)
        else $error("busy not raised after program strobe");
    wr_busy_len_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        ($rose(ready_busy_n_o) && cmd_reg != fuse_prog_pkg::CMD_CHIP_ERASE) |-> blen_reg == WR_LEN)
        else $error("write busy length wrong");
    erase_busy_len_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        ($rose(ready_busy_n_o) && cmd_reg == fuse_prog_pkg::CMD_CHIP_ERASE) |-> blen_reg == ERASE_LEN)
        else $error("erase busy length wrong");
    bus_release_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (clk_en_i && par_ctrl_i.out_en_n) |=> !data_oe_o)
        else $error("data bus not released");
    read_drive_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        $rose(data_oe_o) |-> $past(is_read) && !$past(par_ctrl_i.out_en_n))
        else $error("bus driven outside a read");
    busy_ignore_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (busy_reg && load_rise) |=> $stable(cmd_reg) && $stable(wdata_reg))
        else $error("load accepted while busy");
    serial_gate_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        $rose(serial_enabled_o) |-> !$past(ser_pins_i.reset_n) && $past(sbit_reg) == fuse_prog_pkg::SER_LAST_BIT)
        else $error("serial enable outside reset or frame");
    serial_out_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        $rose(prog_serial_out_o) |-> !$past(ser_pins_i.reset_n) && $past(sck_prev_reg))
        else $error("serial output moved outside falling sck");

    lock_write_c: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
        wr_fall && !busy_reg && cmd_reg == fuse_prog_pkg::CMD_LOCK_WR);
    erase_c: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
        wr_fall && !busy_reg && cmd_reg == fuse_prog_pkg::CMD_CHIP_ERASE);
    fuse_read_c: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
        data_oe_o && cmd_reg == fuse_prog_pkg::CMD_FUSE_RD);
    serial_en_c: cover property (@(posedge mclk_i) disable iff (!rst_n_i) $rose(serial_enabled_o));
endmodule // fuse_lock_prog

//--- sim/prog_model.sv
/*
 * Behavioural parallel/serial programmer that faces the programming port.
 * Assumes the bench calls its tasks; pins change on falling mclk_i edges.
 */
`timescale 1ns/1ps
module prog_model (
    input wire logic mclk_i,
    input wire logic [7:0] dev_data_i,
    input wire logic dev_oe_i,
    input wire logic ready_busy_n_i,
    input wire logic prog_serial_out_i,
    output fuse_prog_pkg::par_ctrl_t par_ctrl_o,
    output logic [7:0] bus_o,
    output fuse_prog_pkg::ser_pins_t ser_pins_o
);
    logic drv_en = 1'h0;
    logic [7:0] drv_data = 8'h00;
    logic [7:0] last_reg = 8'h00;
    // Nobody drives: toggle, so a stale byte can never read as valid
    assign bus_o = dev_oe_i ? dev_data_i : (drv_en ? drv_data : ~last_reg);
    always @(posedge mclk_i) begin
        last_reg <= bus_o;
    end
    initial begin
        par_ctrl_o = '{1'h0, 2'h0, 1'h0, 1'h0, 1'h1, 1'h1};
        ser_pins_o = '{1'h1, 1'h0, 1'h0};
    end
    task automatic load(input logic [1:0] sel, input logic [7:0] val);
        @(negedge mclk_i);
        par_ctrl_o.load_sel = sel;
        drv_data = val;
        drv_en = 1'h1;
        par_ctrl_o.load_strobe = 1'h1;
        @(negedge mclk_i);
        par_ctrl_o.load_strobe = 1'h0;
        @(negedge mclk_i);
        drv_en = 1'h0;
    endtask
    task automatic strobe();
        @(negedge mclk_i);
        par_ctrl_o.prog_strobe_n = 1'h0;
        @(negedge mclk_i);
        par_ctrl_o.prog_strobe_n = 1'h1;
    endtask
    // Bounded wait for ready; counts low cycles seen
    task automatic wait_ready(output int n, output logic first_lo);
        n = 0;
        first_lo = 1'h0;
        // First look is at the strobe's own release edge, so no busy cycle is lost
        for (int i = 0; i < 300; i++) begin
            if (ready_busy_n_i === 1'h0) begin
                n++;
                if (i == 0) first_lo = 1'h1;
            end else if (i >= 2) begin
                break;
            end
            @(negedge mclk_i);
        end
    endtask
    task automatic read(input logic hi, input logic lo, output logic [7:0] val, output logic oe, output logic rel);
        @(negedge mclk_i);
        par_ctrl_o.byte_select_hi = hi;
        par_ctrl_o.byte_select_lo = lo;
        par_ctrl_o.out_en_n = 1'h0;
        repeat (3) @(negedge mclk_i);
        val = bus_o;
        oe = dev_oe_i;
        par_ctrl_o.out_en_n = 1'h1;
        repeat (2) @(negedge mclk_i);
        rel = ~dev_oe_i;
    endtask
    task automatic ser_mode(input logic on);
        @(negedge mclk_i);
        ser_pins_o.reset_n = ~on;
    endtask
    // MSB first, two cycles per phase; echo taken one cycle into the low phase of bits 15 to 8
    task automatic ser_xfer(input logic [31:0] word, output logic [7:0] echo);
        echo = 8'h00;
        for (int i = 31; i >= 0; i--) begin
            @(negedge mclk_i);
            ser_pins_o.sck = 1'h0;
            ser_pins_o.prog_serial_in = word[i];
            @(negedge mclk_i);
            if (i <= 15 && i >= 8) echo[i-8] = prog_serial_out_i;
            @(negedge mclk_i);
            ser_pins_o.sck = 1'h1;
            @(negedge mclk_i);
        end
        @(negedge mclk_i);
        ser_pins_o.sck = 1'h0;
    endtask
endmodule // prog_model

//--- sim/tb_top.sv
/*
 * Self-checking bench for fuse_lock_prog with shortened busy counts.
 * Assumes prog_model drives all pins; clock enable is tied high.
 */
`timescale 1ns/1ps
module tb_top;
    localparam int WR_CYC = 20;
    localparam int ERASE_CYC = 40;
    logic mclk_i = 1'h0;
    logic rst_n_i = 1'h0;
    fuse_prog_pkg::par_ctrl_t par_ctrl;
    fuse_prog_pkg::ser_pins_t ser_pins;
    logic [7:0] bus;
    logic [7:0] data_o;
    logic data_oe;
    logic ready_busy_n;
    logic ser_out;
    logic ser_en;
    int n_mismatch = 0;
    int n_compared = 0;
    int cyc = 0;
    int n;
    logic first_lo;
    logic [7:0] val;
    logic [7:0] lock_exp;
    logic oe;
    logic rel;
    fuse_lock_prog #(.WR_CYC(WR_CYC), .ERASE_CYC(ERASE_CYC)) i_dut (
        .mclk_i(mclk_i), .rst_n_i(rst_n_i), .clk_en_i(1'h1), .par_ctrl_i(par_ctrl), .data_i(bus),
        .data_o(data_o), .data_oe_o(data_oe), .ready_busy_n_o(ready_busy_n), .ser_pins_i(ser_pins),
        .prog_serial_out_o(ser_out), .serial_enabled_o(ser_en));
    prog_model i_prog (
        .mclk_i(mclk_i), .dev_data_i(data_o), .dev_oe_i(data_oe), .ready_busy_n_i(ready_busy_n),
        .prog_serial_out_i(ser_out), .par_ctrl_o(par_ctrl), .bus_o(bus), .ser_pins_o(ser_pins));
    initial begin
        forever #2.5 mclk_i = ~mclk_i;
    end
    task automatic summarize();
        $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Runs far below this; a hang lands here
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 20000) begin
            $display("Error at %0t: timeout before the tests ended", $time);
            n_mismatch++;
            summarize();
        end
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic write_op(input logic [7:0] cmd, input logic [7:0] d, input int exp_n);
        i_prog.load(fuse_prog_pkg::LOAD_CMD, cmd);
        i_prog.load(fuse_prog_pkg::LOAD_DATA, d);
        i_prog.strobe();
        i_prog.wait_ready(n, first_lo);
        check(n, exp_n);
        if (exp_n > 0) check(first_lo, 1);
    endtask
    task automatic fuse_table();
        i_prog.load(fuse_prog_pkg::LOAD_CMD, fuse_prog_pkg::CMD_FUSE_RD);
        for (int s = 0; s < 4; s++) begin
            i_prog.read(s[1], s[0], val, oe, rel);
            check(val, (s == 1) ? lock_exp : fuse_prog_pkg::STORE_INIT[8*((s == 3) ? 1 : s)+:8]);
            check({oe, rel}, 2'h3);
        end
    endtask
    initial begin
        repeat (5) @(negedge mclk_i);
        check({data_oe, ready_busy_n, ser_en}, 3'h2);
        rst_n_i = 1'h1;
        lock_exp = fuse_prog_pkg::STORE_INIT[31:24];
        fuse_table();
        write_op(fuse_prog_pkg::CMD_LOCK_WR, 8'hF0, WR_CYC);
        lock_exp = lock_exp & 8'hF0;
        // Strobe and load land mid-busy; both must be dropped
        i_prog.load(fuse_prog_pkg::LOAD_CMD, fuse_prog_pkg::CMD_LOCK_WR);
        i_prog.load(fuse_prog_pkg::LOAD_DATA, 8'h3C);
        i_prog.strobe();
        i_prog.load(fuse_prog_pkg::LOAD_CMD, fuse_prog_pkg::CMD_FUSE_RD);
        i_prog.strobe();
        i_prog.wait_ready(n, first_lo);
        check(n, WR_CYC - 5);
        i_prog.read(1'h0, 1'h1, val, oe, rel);
        check(oe, 0);
        lock_exp = lock_exp & 8'h3C;
        fuse_table();
        i_prog.load(fuse_prog_pkg::LOAD_CMD, fuse_prog_pkg::CMD_SIG_RD);
        for (int a = 0; a < 4; a++) begin
            i_prog.load(fuse_prog_pkg::LOAD_ADDR_LO, 8'(a));
            i_prog.read(1'h0, 1'h0, val, oe, rel);
            check(val, (a <= 2) ? fuse_prog_pkg::STORE_INIT[8*(4+a)+:8] : 8'hFF);
        end
        repeat (2) begin
            i_prog.read(1'h0, 1'h1, val, oe, rel);
            check(val, fuse_prog_pkg::STORE_INIT[63:56]);
        end
        write_op(fuse_prog_pkg::CMD_FUSE_WR, 8'h00, WR_CYC);
        write_op(fuse_prog_pkg::CMD_FLASH_WR, 8'h00, WR_CYC);
        write_op(fuse_prog_pkg::CMD_EEPROM_WR, 8'h00, WR_CYC);
        write_op(fuse_prog_pkg::CMD_FUSE_RD, 8'h00, 0);
        write_op(fuse_prog_pkg::CMD_CHIP_ERASE, 8'h00, ERASE_CYC);
        lock_exp = 8'hFF;
        fuse_table();
        i_prog.ser_xfer(32'hAC53_0000, val);
        check(ser_en, 0);
        i_prog.ser_mode(1'h1);
        i_prog.ser_xfer(32'hAC53_0000, val);
        check(val, 8'h53);
        check(ser_en, 1);
        i_prog.ser_mode(1'h0);
        repeat (2) @(negedge mclk_i);
        check(ser_en, 0);
        i_prog.ser_mode(1'h1);
        i_prog.ser_xfer(32'hAC54_0000, val);
        check(ser_en, 0);
        summarize();
    end
endmodule // tb_top
